// ### hw/idr_router.sv
`timescale 1ns/1ns
module idr_router
    import idr_pkg::*;
#(
    parameter int NUM_SRC = 26,
    parameter int NUM_MOD = 16
) (
    // clock and reset
    input  wire logic                        mclk,
    input  wire logic                        nrst,
    // main source side, already latched and enabled by the source logic
    input  wire logic [NUM_SRC-1:0]          srcPending,
    // destination masks, one word per destination
    input  wire logic [NUM_DEST*NUM_SRC-1:0] destSourceMask,
    output logic      [NUM_DEST*NUM_SRC-1:0] destActiveSources,
    output logic      [NUM_DEST-1:0]         destIrq,
    // port module hierarchy
    input  wire logic [NUM_MOD-1:0]          moduleIrqIn,
    input  wire logic [NUM_MOD-1:0]          modulePolarityInvert,
    input  wire logic [2*NUM_MOD-1:0]        moduleTriggerSelect,
    input  wire logic [NUM_MOD-1:0]          moduleLatchClear,
    input  wire logic [NUM_MOD-1:0]          moduleLatchBypass,
    input  wire logic [NUM_MOD-1:0]          moduleIrqEnable,
    output logic      [NUM_MOD-1:0]          moduleRawValue,
    output logic      [NUM_MOD-1:0]          moduleLatchedFlag,
    output logic      [NUM_MOD-1:0]          moduleActiveIdent,
    output logic                             portModuleAggregateSource,
    // external inputs, corrected to active high
    input  wire logic [NUM_EXT-1:0]          extIrqInput,
    input  wire logic [NUM_EXT-1:0]          extInputPolarity,
    output logic      [NUM_EXT-1:0]          extSourceValue,
    // external outputs on gpio pins
    input  wire logic [NUM_EXT-1:0]          extOutputPolarity,
    input  wire logic [NUM_EXT-1:0]          extOutputDriveMode,
    input  wire logic [NUM_EXT-1:0]          extOutputOnPin,
    output logic      [NUM_EXT-1:0]          extIrqOutput,
    output logic      [NUM_EXT-1:0]          extIrqOutputEn,
    output logic      [NUM_EXT-1:0]          extInputGated
);
    // the fixed source slots for ext inputs and aggregate need three bits
    if (NUM_SRC < FIRST_FREE || NUM_MOD < 1) begin : g_bad_params
        $error("idr_router: source or module count too small");
    end

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [NUM_MOD-1:0]          rawPrev;
        logic [NUM_MOD-1:0]          raw;
        logic [NUM_MOD-1:0]          latched;
        logic [NUM_MOD-1:0]          ident;
        logic                        agg;
        logic [NUM_EXT-1:0]          extSrc;
        logic [NUM_EXT-1:0]          gated;
        logic [NUM_DEST*NUM_SRC-1:0] act;
        logic [NUM_DEST-1:0]         dst;
        logic [NUM_EXT-1:0]          pinOut;
        logic [NUM_EXT-1:0]          pinOe;
    } idr_state_t;

    idr_state_t st_q;
    idr_state_t st_d;

    // edge detect shared by every module latch
    function automatic logic trig_hit(input logic [1:0] sel,
                                      input logic       now,
                                      input logic       prev);
        unique case (sel)
            TRIG_LEVEL: trig_hit = now;
            TRIG_EDGE:  trig_hit = now ^ prev;
            TRIG_FALL:  trig_hit = prev & ~now;
            TRIG_RISE:  trig_hit = now & ~prev;
        endcase
    endfunction

    logic [NUM_SRC-1:0] srcVec;
    logic [NUM_DEST-1:0] dstNow;
    logic [NUM_SRC-1:0] actNow [NUM_DEST];

    // aggregate and external inputs join the main vector; internal high
    always_comb begin
        srcVec = srcPending;
        srcVec[EXT_SRC_BASE +: NUM_EXT] = st_q.extSrc;
        srcVec[AGG_SRC_IDX] = st_q.agg;
    end

    // one identical slice per destination
    genvar d;
    generate
        for (d = 0; d < NUM_DEST; d++) begin : g_dest
            assign actNow[d] = srcVec &
                destSourceMask[d*NUM_SRC +: NUM_SRC];
            assign dstNow[d] = |actNow[d];
        end
    endgenerate

    always_comb begin
        st_d = st_q;
        // ****************************************
        // port module hierarchy
        // ****************************************
        st_d.raw = moduleIrqIn ^ modulePolarityInvert;
        st_d.rawPrev = st_q.raw;
        for (int m = 0; m < NUM_MOD; m++) begin
            // set wins over the write-one clear
            if (trig_hit(moduleTriggerSelect[2*m +: 2], st_q.raw[m],
                         st_q.rawPrev[m])) begin
                st_d.latched[m] = 1'b1;
            end else if (moduleLatchClear[m]) begin
                st_d.latched[m] = 1'b0;
            end
            st_d.ident[m] = moduleIrqEnable[m] &
                (moduleLatchBypass[m] ? st_q.raw[m]
                                      : st_q.latched[m]);
        end
        // aggregate costs one more cycle, kept so every output is a flop
        st_d.agg = |st_q.ident;
        // ****************************************
        // external inputs and destinations
        // ****************************************
        st_d.gated = extOutputOnPin;
        st_d.extSrc = (extIrqInput ^ extInputPolarity)
                      & ~extOutputOnPin;
        for (int dd = 0; dd < NUM_DEST; dd++) begin
            st_d.act[dd*NUM_SRC +: NUM_SRC] = actNow[dd];
        end
        st_d.dst = dstNow;
        // the pin enable follows the overlay bit, so software must set
        // drive mode and polarity first or a glitch can reach the wire
        for (int e = 0; e < NUM_EXT; e++) begin
            // polarity applied after leaving the controller
            if (extOutputDriveMode[e] && !extOutputPolarity[e]) begin
                st_d.pinOut[e] = 1'b0;
                st_d.pinOe[e]  = extOutputOnPin[e] & dstNow[DEST_EXT0+e];
            end else begin
                st_d.pinOut[e] = dstNow[DEST_EXT0+e] ^ ~extOutputPolarity[e];
                st_d.pinOe[e]  = extOutputOnPin[e];
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // outputs straight from flops
    assign moduleRawValue            = st_q.raw;
    assign moduleLatchedFlag         = st_q.latched;
    assign moduleActiveIdent         = st_q.ident;
    assign portModuleAggregateSource = st_q.agg;
    assign extSourceValue            = st_q.extSrc;
    assign extInputGated             = st_q.gated;
    assign destActiveSources         = st_q.act;
    assign destIrq                   = st_q.dst;
    assign extIrqOutput              = st_q.pinOut;
    assign extIrqOutputEn            = st_q.pinOe;

    // ****************************************
    // checks
    // ****************************************
    chk_agg_any: assert property (@(posedge mclk) disable iff (!nrst)
        (|moduleActiveIdent) |=> portModuleAggregateSource)
        else $error("aggregate missed an ident");
    chk_agg_none: assert property (@(posedge mclk) disable iff (!nrst)
        !(|moduleActiveIdent) |=> !portModuleAggregateSource)
        else $error("aggregate set without ident");
    chk_raw_pol: assert property (@(posedge mclk) disable iff (!nrst)
        1'b1 |=> moduleRawValue ==
            ($past(moduleIrqIn) ^ $past(modulePolarityInvert)))
        else $error("module raw polarity wrong");
    chk_level_set: assert property (@(posedge mclk) disable iff (!nrst)
        (moduleTriggerSelect[1:0] == TRIG_LEVEL && moduleRawValue[0])
        |=> moduleLatchedFlag[0])
        else $error("level latch not set");
    chk_rise_set: assert property (@(posedge mclk) disable iff (!nrst)
        (moduleTriggerSelect[1:0] == TRIG_RISE && moduleRawValue[0]
         && !$past(moduleRawValue[0])) |=> moduleLatchedFlag[0])
        else $error("rise latch not set");
    chk_clear_hold: assert property (@(posedge mclk) disable iff (!nrst)
        (moduleTriggerSelect[1:0] == TRIG_RISE && moduleLatchClear[0]
         && !(moduleRawValue[0] && !$past(moduleRawValue[0])))
        |=> !moduleLatchedFlag[0])
        else $error("clear did not clear");
    chk_mask_gate: assert property (@(posedge mclk) disable iff (!nrst)
        1'b1 |=> (destActiveSources[NUM_SRC-1:0] &
            ~$past(destSourceMask[NUM_SRC-1:0])) == '0)
        else $error("unmasked source reached destination");
    chk_dest_or: assert property (@(posedge mclk) disable iff (!nrst)
        destIrq[0] == |destActiveSources[NUM_SRC-1:0])
        else $error("destination not or of ident");
    chk_oc_low: assert property (@(posedge mclk) disable iff (!nrst)
        extIrqOutputEn[0] && extOutputDriveMode[0] && !extOutputPolarity[0]
        && $stable(extOutputDriveMode[0]) && $stable(extOutputPolarity[0])
        |-> !extIrqOutput[0])
        else $error("open collector drove high");
    chk_push_pull: assert property (@(posedge mclk) disable iff (!nrst)
        (extOutputOnPin[0] && !extOutputDriveMode[0])
        |=> extIrqOutputEn[0])
        else $error("push pull not driven");

    // ****************************************
    // more edge trigger checks
    // ****************************************
    // falling change sets the flag on the fall variant
    chk_fall_set: assert property (@(posedge mclk) disable iff (!nrst)
        (moduleTriggerSelect[1:0] == TRIG_FALL && !moduleRawValue[0]
         && $past(moduleRawValue[0])) |=> moduleLatchedFlag[0])
        else $error("fall latch not set");

    // any change sets the flag on the both-edge variant
    chk_edge_set: assert property (@(posedge mclk) disable iff (!nrst)
        (moduleTriggerSelect[1:0] == TRIG_EDGE && (moduleRawValue[0]
         != $past(moduleRawValue[0]))) |=> moduleLatchedFlag[0])
        else $error("edge latch not set");

    // a quiet input must not set an edge flag out of nowhere
    chk_edge_quiet: assert property (@(posedge mclk) disable iff (!nrst)
        (moduleTriggerSelect[1:0] != TRIG_LEVEL && !moduleLatchedFlag[0]
         && moduleRawValue[0] == $past(moduleRawValue[0]))
        |=> !moduleLatchedFlag[0])
        else $error("edge latch set without change");

    // ****************************************
    // enable, bypass and ident checks
    // ****************************************
    // a disabled module never shows an ident
    chk_ident_gate: assert property (@(posedge mclk) disable iff (!nrst)
        !moduleIrqEnable[0] |=> !moduleActiveIdent[0])
        else $error("ident set while disabled");

    // bypass takes the raw value and ignores the latch
    chk_bypass_raw: assert property (@(posedge mclk) disable iff (!nrst)
        (moduleIrqEnable[0] && moduleLatchBypass[0])
        |=> moduleActiveIdent[0] == $past(moduleRawValue[0]))
        else $error("bypass ident wrong");

    // without bypass the ident follows the latched flag
    chk_ident_latch: assert property (@(posedge mclk) disable iff (!nrst)
        (moduleIrqEnable[0] && !moduleLatchBypass[0])
        |=> moduleActiveIdent[0] == $past(moduleLatchedFlag[0]))
        else $error("ident does not follow latch");

    // ****************************************
    // external pin checks
    // ****************************************
    // input correction, forced off while the pin carries the output
    chk_ext_in: assert property (@(posedge mclk) disable iff (!nrst)
        1'b1 |=> extSourceValue == (($past(extIrqInput)
            ^ $past(extInputPolarity))
            & ~$past(extOutputOnPin)))
        else $error("external input correction wrong");

    // gating flag shows the overlay one cycle later
    chk_gated: assert property (@(posedge mclk) disable iff (!nrst)
        1'b1 |=> extInputGated == $past(extOutputOnPin))
        else $error("input gating wrong");

    // push-pull pin level is the destination with output polarity
    chk_pp_level: assert property (@(posedge mclk) disable iff (!nrst)
        extIrqOutputEn[1] && !$past(extOutputDriveMode[1])
        |-> extIrqOutput[1] ==
            (destIrq[DEST_EXT1] ^ ~$past(extOutputPolarity[1])))
        else $error("push pull level wrong");

    // open collector lets go of the pin while the irq is idle
    chk_oc_release: assert property (@(posedge mclk) disable iff (!nrst)
        $past(extOutputDriveMode[0]) && !$past(extOutputPolarity[0])
        && !destIrq[DEST_EXT0] |-> !extIrqOutputEn[0])
        else $error("open collector drove while idle");

    // no overlay, no drive
    chk_oe_off: assert property (@(posedge mclk) disable iff (!nrst)
        !$past(extOutputOnPin[0]) |-> !extIrqOutputEn[0])
        else $error("pin driven without overlay");

    // the last destination slice is an or of its own ident word
    chk_dest_idx: assert property (@(posedge mclk) disable iff (!nrst)
        destIrq[3] == |destActiveSources[3*NUM_SRC +: NUM_SRC])
        else $error("destination three not or of ident");

    // ****************************************
    // covers
    // ****************************************
    cov_oc: cover property (@(posedge mclk) disable iff (!nrst)
        extIrqOutputEn[0] && !extIrqOutput[0]);
    cov_fall: cover property (@(posedge mclk) disable iff (!nrst)
        $rose(moduleLatchedFlag[4]) && !moduleRawValue[4]);
    cov_bypass: cover property (@(posedge mclk) disable iff (!nrst)
        $rose(moduleActiveIdent[5]));
    cov_agg: cover property (@(posedge mclk) disable iff (!nrst)
        $rose(portModuleAggregateSource));
    cov_dest: cover property (@(posedge mclk) disable iff (!nrst)
        $rose(destIrq[DEST_EXT1]));
endmodule

// ### hw/idr_pkg.sv
// How it works
// - four destinations built from one generate loop over the destination index.
// - a source reaches a destination only where its mask bit is set.
// - each destination shows which enabled, latched sources are mapped to it.
// - port module interrupts run through their own latch hierarchy first.
// - each module input gets its own polarity inversion before detection.
// - module raw, trigger, latch, clear, bypass, enable and ident match source logic.
// - all module idents fold into the one aggregate port module source.
// - two external inputs as sources and two outputs as destinations.
// - external inputs and outputs work at once, except that an input is forced off while its pin carries the output.
// - each external input and output has its own polarity bit.
// - a destination output mapped onto a pin replaces that input function.
// - drive mode 0 drives the output pin at both levels.
// - drive mode 1 with polarity 0 emulates open collector.
// - everything inside the controller is active high.
// - level trigger sets the latch every cycle while the input is active.
// - edge triggers set the latch only on the selected change of the input.
package idr_pkg;
    // ****************************************
    // trigger encodings and sizes
    // ****************************************
    localparam logic [1:0] TRIG_LEVEL   = 2'h0;
    localparam logic [1:0] TRIG_EDGE    = 2'h1;
    localparam logic [1:0] TRIG_FALL    = 2'h2;
    localparam logic [1:0] TRIG_RISE    = 2'h3;
    localparam int         NUM_DEST     = 4;
    localparam int         NUM_EXT      = 2;
    localparam int         DEST_EXT0    = 2;
    localparam int         DEST_EXT1    = 3;
    localparam int         EXT_SRC_BASE = 0;
    localparam int         AGG_SRC_IDX  = 2;
    localparam int         FIRST_FREE   = 3;
endpackage

// ### dv/idr_ext_partner.sv
`timescale 1ns/1ns
// ****************************************
// board wire shared with other irq drivers
// ****************************************
module idr_ext_partner (
    // pins of the block
    input  wire logic [1:0] pinOut,
    input  wire logic [1:0] pinEn,
    // other board drivers, they only ever pull low
    input  wire logic [1:0] peerPullLow,
    // level seen on the wire
    output logic      [1:0] wireLevel
);
    // released wire floats to the pull-up, any low driver wins
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            if (peerPullLow[i] || (pinEn[i] && !pinOut[i])) begin
                wireLevel[i] = 1'b0;
            end else begin
                wireLevel[i] = 1'b1;
            end
        end
    end
endmodule

// ### dv/tb_top.sv
`timescale 1ns/1ns
module tb_top
    import idr_pkg::*;
;
    logic mclk = 1'b0, nrst = 1'b0;
    logic [25:0] srcPending;
    logic [103:0] destSourceMask, destActiveSources;
    logic [3:0] destIrq;
    logic [15:0] moduleIrqIn, modulePolarityInvert, moduleLatchClear;
    logic [15:0] moduleLatchBypass, moduleIrqEnable, moduleRawValue;
    logic [15:0] moduleLatchedFlag, moduleActiveIdent;
    logic [31:0] moduleTriggerSelect;
    logic portModuleAggregateSource;
    logic [1:0] extIrqInput, extInputPolarity, extSourceValue, extOutputOnPin;
    logic [1:0] extOutputPolarity, extOutputDriveMode, extIrqOutput;
    logic [1:0] extIrqOutputEn, extInputGated, peerPullLow, wireLevel;
    int num_errors = 0, n_tests = 0;
    always #2 mclk = ~mclk;
    idr_router #(.NUM_SRC(26), .NUM_MOD(16)) idr_router_inst (.mclk, .nrst,
        .srcPending, .destSourceMask, .destActiveSources, .destIrq,
        .moduleIrqIn, .modulePolarityInvert, .moduleTriggerSelect,
        .moduleLatchClear, .moduleLatchBypass, .moduleIrqEnable,
        .moduleRawValue, .moduleLatchedFlag, .moduleActiveIdent,
        .portModuleAggregateSource, .extIrqInput, .extInputPolarity,
        .extSourceValue, .extOutputPolarity, .extOutputDriveMode,
        .extOutputOnPin, .extIrqOutput, .extIrqOutputEn, .extInputGated);
    idr_ext_partner idr_ext_partner_inst (.pinOut(extIrqOutput),
        .pinEn(extIrqOutputEn), .peerPullLow, .wireLevel);
    // ****************************************
    // helpers
    // ****************************************
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // sample one time unit after the edge so the flops have landed
    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // watchdog, the tests need about eighty-five cycles
    initial begin
        #4000;
        num_errors++;
        give_verdict();
    end
    initial begin
        {srcPending, destSourceMask, moduleIrqIn, moduleLatchClear} = '0;
        {modulePolarityInvert, moduleLatchBypass, moduleIrqEnable} = '0;
        {moduleTriggerSelect, extIrqInput, extInputPolarity} = '0;
        {extOutputPolarity, extOutputDriveMode, extOutputOnPin} = '0;
        peerPullLow = '0;
        repeat (10) @(posedge mclk);
        nrst <= 1'b1;
        // level path through raw, latch, ident, aggregate, destination
        @(posedge mclk);
        moduleIrqIn <= 16'h1;
        moduleIrqEnable <= 16'h1;
        modulePolarityInvert <= 16'h2;
        destSourceMask <= {78'h0, 26'h4};
        wt(1); chk("raw", moduleRawValue, 16'h3);
        wt(1); chk("latched", moduleLatchedFlag, 16'h3);
        wt(1); chk("ident", moduleActiveIdent, 16'h1);
        wt(1); chk("aggregate", portModuleAggregateSource, 1'b1);
        wt(1); chk("dest0", destIrq[0], 1'b1);
        chk("active0", destActiveSources[25:0], 26'h4);
        // a clear while the level is still active does not stick
        @(posedge mclk) moduleLatchClear <= 16'h1;
        @(posedge mclk) moduleLatchClear <= 16'h0;
        wt(1); chk("relatch", moduleLatchedFlag, 16'h3);
        @(posedge mclk) {moduleIrqIn, modulePolarityInvert} <= '0;
        wt(3); chk("held", moduleLatchedFlag, 16'h3);
        @(posedge mclk) moduleLatchClear <= 16'h3;
        @(posedge mclk) moduleLatchClear <= 16'h0;
        wt(2); chk("cleared", moduleLatchedFlag, 16'h0);
        wt(2); chk("dest0 off", destIrq[0], 1'b0);
        $display("test level done");
        // edge variants on module 4, bypassed module 5 rides along
        moduleLatchBypass <= 16'h20;
        moduleIrqEnable <= 16'h20;
        for (int m = 1; m < 4; m++) begin
            @(posedge mclk) moduleTriggerSelect <= 32'(m) << 8;
            @(posedge mclk) moduleIrqIn <= 16'h30;
            wt(3); chk("up", moduleLatchedFlag[4], m != 2);
            chk("bypass up", moduleActiveIdent[5], 1'b1);
            @(posedge mclk) moduleLatchClear <= 16'h10;
            @(posedge mclk) {moduleLatchClear, moduleIrqIn} <= '0;
            wt(3); chk("down", moduleLatchedFlag[4], m != 3);
            chk("bypass down", moduleActiveIdent[5], 1'b0);
            @(posedge mclk) moduleLatchClear <= 16'h10;
            @(posedge mclk) moduleLatchClear <= 16'h0;
        end
        $display("test edges done");
        // per destination masks and identity vectors
        @(posedge mclk) srcPending <= 26'h20;
        destSourceMask <= {26'h60, 26'h40, 26'h20, 26'h0};
        extInputPolarity <= 2'b10;
        wt(3);
        for (int d = 0; d < 4; d++) begin
            chk("ident vec", destActiveSources[d*26+:26],
                destSourceMask[d*26+:26] & 26'h22);
        end
        chk("dest irqs", destIrq, 4'b1010);
        chk("ext in", extSourceValue, 2'b10);
        $display("test masks done");
        // outputs: out0 open collector, out1 push-pull active high
        @(posedge mclk) extOutputDriveMode <= 2'b01;
        extOutputPolarity <= 2'b10;
        @(posedge mclk) extOutputOnPin <= 2'b11;
        wt(3); chk("oc idle", {extIrqOutputEn[0], wireLevel[0]}, 2'b01);
        chk("pp high", {extIrqOutputEn[1], extIrqOutput[1]}, 2'b11);
        chk("replaced", extSourceValue, 2'b00);
        chk("gated", extInputGated, 2'b11);
        @(posedge mclk) srcPending <= 26'h40;
        wt(4); chk("oc low", {extIrqOutputEn[0], wireLevel[0]}, 2'b10);
        chk("pp on", {extIrqOutputEn[1], extIrqOutput[1]}, 2'b11);
        @(posedge mclk) srcPending <= 26'h0;
        peerPullLow <= 2'b01;
        wt(4); chk("peer", {extIrqOutputEn[0], wireLevel[0]}, 2'b00);
        chk("pp low", {extIrqOutputEn[1], extIrqOutput[1]}, 2'b10);
        $display("test outputs done");
        give_verdict();
    end
endmodule
